/* File: wrc_pkg.sv */
// Package with modes, states and timing constants of the wake-up and reset controller.
package wrc_pkg;

  // Power modes requested by software.
  typedef enum logic [2:0] {
    WRC_MODE_RUN = 3'h0,
    WRC_MODE_SLEEP = 3'h1,
    WRC_MODE_DEEP_SLEEP = 3'h2,
    WRC_MODE_POWER_DOWN = 3'h3,
    WRC_MODE_DEEP_PD = 3'h4
  } wrc_mode_t;

  // Controller states, one-hot.
  typedef enum logic [5:0] {
    WRC_ST_RESET = 6'h01,
    WRC_ST_INIT = 6'h02,
    WRC_ST_RUN = 6'h04,
    WRC_ST_SLEEP = 6'h08,
    WRC_ST_DEEP = 6'h10,
    WRC_ST_DPD = 6'h20
  } wrc_state_t;

  // Reset cause bit positions.
  localparam int WRC_RST_PIN = 0;
  localparam int WRC_RST_WDOG = 1;
  localparam int WRC_RST_POR = 2;
  localparam int WRC_RST_BOD = 3;
  localparam int WRC_RST_SRCS = 4;

  // Oscillator and flash start-up time and the derived cycle count.
  localparam int WRC_CLK_MHZ = 20;
  localparam int WRC_INIT_TIME_NS = 1000;
  localparam int WRC_INIT_CYCLES = (WRC_INIT_TIME_NS * WRC_CLK_MHZ + 999) / 1000;
  localparam int WRC_INIT_W = 8;

  // Self-wake timer width.
  localparam int WRC_WKT_W = 32;

  // Processor fetch address after reset.
  localparam logic [31:0] WRC_RESET_VECTOR = 32'h0000_0000;

endpackage

/* File: wrc_sync_bit.sv */
// Two-stage synchroniser used for wake-source enable bits.
`timescale 1ns/1ns
module wrc_sync_bit (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic d,
  output logic q
);
  logic meta_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

/* File: wrc_wakeup_reset_ctrl.sv */
// Wake-up qualification and chip reset sequencing controller.
`timescale 1ns/1ns
module wrc_wakeup_reset_ctrl #(
  parameter int WKT_W = wrc_pkg::WRC_WKT_W,
  parameter int INIT_CYCLES = wrc_pkg::WRC_INIT_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Power mode request from the processor
  input wire logic mode_req,
  input wire wrc_pkg::wrc_mode_t mode_sel,
  // Interrupt sources and controller enables
  input wire logic irq_any_enabled,
  input wire logic pin_irq,
  input wire logic pin_irq_nested_irq_controller_en,
  input wire logic pin_wake_start_enable,
  input wire logic bod_irq,
  input wire logic bod_irq_nested_irq_controller_en,
  input wire logic wdog_irq,
  input wire logic wdog_irq_nested_irq_controller_en,
  input wire logic serial_irq,
  input wire logic serial_irq_nested_irq_controller_en,
  input wire logic touch_irq,
  input wire logic touch_irq_nested_irq_controller_en,
  input wire logic wkt_irq_nested_irq_controller_en,
  // Peripheral wake start enables
  input wire logic bod_wake_start_en,
  input wire logic wdog_wake_start_en,
  input wire logic wkt_wake_start_en,
  input wire logic serial_wake_start_en,
  input wire logic touch_wake_start_en,
  // Brownout detector
  input wire logic brownout_detect,
  input wire logic brownout_control_irq_en,
  input wire logic brownout_control_rst_en,
  input wire logic sleep_power_config_bod_on,
  // Watchdog
  input wire logic wdog_running,
  input wire logic watchdog_mode_reg_irq_en,
  input wire logic watchdog_mode_reg_rst_en,
  input wire logic wdog_reset_req,
  input wire logic sleep_power_config_watchdog_oscillator_on,
  // Self-wake timer
  input wire logic wkt_count_wr,
  input wire logic [WKT_W-1:0] wkt_count_val,
  input wire logic wkt_clk_lowpower_sel,
  input wire logic lp_osc_tick,
  // Serial and touch configuration
  input wire logic serial_slave_mode,
  input wire logic serial_ext_clk,
  input wire logic touch_clk_from_watchdog_oscillator,
  // Deep power-down control
  input wire logic dpd_wakeup_pin_en,
  input wire logic dpd_reset_pin_en,
  input wire logic dpd_lp_osc_en,
  input wire logic dpd_lp_osc_keep,
  // Pins and reset sources
  input wire logic reset_pin_n,
  input wire logic pin_function_reset_en,
  input wire logic wakeup_pin_n,
  input wire logic por_detect,
  // Outputs
  output logic core_clk_en,
  output logic periph_clk_en,
  output logic deep_clocks_off,
  output logic dpd_power_off,
  output logic fro_enable,
  output logic flash_init,
  output logic chip_reset,
  output logic core_reset,
  output logic [31:0] fetch_addr,
  output logic wake_req,
  output logic [WKT_W-1:0] wkt_count,
  output logic wkt_expired,
  output logic [wrc_pkg::WRC_RST_SRCS-1:0] reset_cause
);
  import wrc_pkg::*;

  wrc_state_t state_q;
  wrc_state_t state_d;
  logic [WRC_INIT_W-1:0] init_cnt_q;
  logic [WKT_W-1:0] wkt_q;
  logic wkt_run_q;
  logic wkt_exp_q;
  logic [WRC_RST_SRCS-1:0] cause_q;
  logic [WRC_RST_SRCS-1:0] rst_src;
  logic any_rst;

  // Synchronised enable bits.
  localparam int NEN = 12;
  logic [NEN-1:0] en_raw;
  logic [NEN-1:0] en_s;

  // The wake start, deep power-down and timer clock enables cross two flops, so a bit set just before a
  // mode request takes effect two cycles later; software must allow for that delay.
  assign en_raw = {pin_function_reset_en, dpd_wakeup_pin_en, dpd_reset_pin_en, dpd_lp_osc_en,
                   dpd_lp_osc_keep, pin_wake_start_enable, bod_wake_start_en,
                   wdog_wake_start_en, wkt_wake_start_en, serial_wake_start_en,
                   touch_wake_start_en, wkt_clk_lowpower_sel};

  genvar gi;
  generate
    for (gi = 0; gi < NEN; gi++) begin : g_sync
      wrc_sync_bit u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .d(en_raw[gi]),
        .q(en_s[gi])
      );
    end
  endgenerate

  logic s_rstpin_en;
  logic s_dpd_wk_en;
  logic s_dpd_rst_en;
  logic s_lp_en;
  logic s_lp_keep;
  logic s_pin_start;
  logic s_bod_start;
  logic s_wdog_start;
  logic s_wkt_start;
  logic s_ser_start;
  logic s_touch_start;
  logic s_wkt_lp;
  assign {s_rstpin_en, s_dpd_wk_en, s_dpd_rst_en, s_lp_en, s_lp_keep, s_pin_start,
          s_bod_start, s_wdog_start, s_wkt_start, s_ser_start, s_touch_start,
          s_wkt_lp} = en_s;

  // Reset gathering; the pin only counts when its reset function is enabled.
  logic pin_rst;
  assign pin_rst = ~reset_pin_n & ((state_q == WRC_ST_DPD) ? s_dpd_rst_en : s_rstpin_en);
  assign rst_src[WRC_RST_PIN] = pin_rst;
  // Watchdog and brownout lose power in deep power-down, so of the reset sources only the pin may restart
  // the chip from there.
  assign rst_src[WRC_RST_WDOG] = wdog_reset_req & watchdog_mode_reg_rst_en & wdog_running
                                 & ((state_q != WRC_ST_DEEP) | sleep_power_config_watchdog_oscillator_on)
                                 & (state_q != WRC_ST_DPD);
  assign rst_src[WRC_RST_POR] = por_detect;
  assign rst_src[WRC_RST_BOD] = brownout_detect & brownout_control_rst_en
                                & ((state_q != WRC_ST_DEEP) | sleep_power_config_bod_on)
                                & (state_q != WRC_ST_DPD);
  assign any_rst = |rst_src;

  // Qualified wake events.
  logic wk_sleep;
  logic wk_pin;
  logic wk_bod;
  logic wk_wdog;
  logic wk_wkt;
  logic wk_ser;
  logic wk_touch;
  logic wk_deep;
  logic wk_dpd;

  assign wk_sleep = irq_any_enabled;
  assign wk_pin = pin_irq & pin_irq_nested_irq_controller_en & s_pin_start;
  assign wk_bod = bod_irq & bod_irq_nested_irq_controller_en & s_bod_start & brownout_control_irq_en
                  & sleep_power_config_bod_on;
  // Watchdog interrupt wake assumes software has enabled and fed the watchdog.
  assign wk_wdog = wdog_irq & wdog_irq_nested_irq_controller_en & s_wdog_start & watchdog_mode_reg_irq_en
                   & wdog_running & sleep_power_config_watchdog_oscillator_on;
  assign wk_wkt = wkt_exp_q & wkt_irq_nested_irq_controller_en & s_wkt_start & s_wkt_lp;
  assign wk_ser = serial_irq & serial_irq_nested_irq_controller_en & s_ser_start & serial_slave_mode
                  & serial_ext_clk;
  assign wk_touch = touch_irq & touch_irq_nested_irq_controller_en & s_touch_start & touch_clk_from_watchdog_oscillator
                    & sleep_power_config_watchdog_oscillator_on;
  assign wk_deep = wk_pin | wk_bod | wk_wdog | wk_wkt | wk_ser | wk_touch;
  assign wk_dpd = (~wakeup_pin_n & s_dpd_wk_en)
                  | (wkt_exp_q & s_lp_en & s_lp_keep & s_wkt_lp);

  // Wake request for each low-power state. It is combinational so that the sequencer
  // leaves the low-power state on the same edge that sees the event.
  always_comb begin
    case (state_q)
      WRC_ST_SLEEP: wake_req = wk_sleep | wk_deep | pin_rst;
      WRC_ST_DEEP: wake_req = wk_deep | any_rst;
      WRC_ST_DPD: wake_req = wk_dpd | pin_rst;
      default: wake_req = 1'b0;
    endcase
  end

  // Main sequencer.
  always_comb begin
    state_d = state_q;
    case (state_q)
      WRC_ST_RESET: begin
        if (!any_rst) begin
          state_d = WRC_ST_INIT;
        end
      end
      WRC_ST_INIT: begin
        // The core stays in reset until oscillator and flash have had their start-up time.
        if (init_cnt_q >= WRC_INIT_W'(INIT_CYCLES - 1)) begin
          state_d = WRC_ST_RUN;
        end
      end
      WRC_ST_RUN: begin
        // A run request or an unknown code leaves the state as it is.
        if (mode_req) begin
          case (mode_sel)
            WRC_MODE_SLEEP: state_d = WRC_ST_SLEEP;
            WRC_MODE_DEEP_SLEEP: state_d = WRC_ST_DEEP;
            WRC_MODE_POWER_DOWN: state_d = WRC_ST_DEEP;
            WRC_MODE_DEEP_PD: state_d = WRC_ST_DPD;
            default: state_d = WRC_ST_RUN;
          endcase
        end
      end
      WRC_ST_SLEEP: begin
        if (wake_req) begin
          state_d = WRC_ST_RUN;
        end
      end
      WRC_ST_DEEP: begin
        // Flash and clocks were stopped, so the start-up time is paid again.
        if (wake_req) begin
          state_d = WRC_ST_INIT;
        end
      end
      WRC_ST_DPD: begin
        // Leaving deep power-down is a full restart of the chip.
        if (wake_req) begin
          state_d = WRC_ST_RESET;
        end
      end
      default: state_d = WRC_ST_RESET;
    endcase
    // Reset sources win over every transition except in deep power-down, where the
    // wake request above already routes an enabled pin into the reset state.
    if (any_rst && state_q != WRC_ST_DPD) begin
      state_d = WRC_ST_RESET;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= WRC_ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Counts the start-up cycles; it rests at zero outside the init state.
  always_ff @(posedge core_clk) begin
    if (reset || state_q != WRC_ST_INIT) begin
      init_cnt_q <= '0;
    end else begin
      init_cnt_q <= init_cnt_q + WRC_INIT_W'(1);
    end
  end

  // Reset cause capture; entering reset replaces old causes with the new ones, which accumulate while in reset.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cause_q <= '0;
    end else if (state_q == WRC_ST_RESET) begin
      cause_q <= cause_q | rst_src;
    end else if (state_d == WRC_ST_RESET) begin
      cause_q <= rst_src;
    end
  end

  // Self-wake timer counts low-power oscillator ticks.
  // Only the reset input or a count write clears it; the count survives every power state.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wkt_q <= '0;
      wkt_run_q <= 1'b0;
      wkt_exp_q <= 1'b0;
    end else if (wkt_count_wr) begin
      wkt_q <= wkt_count_val;
      wkt_run_q <= (wkt_count_val != '0);
      // An expiry on the same edge as a new count is kept, so that its wake is not lost.
      wkt_exp_q <= wkt_run_q && lp_osc_tick && (wkt_q == WKT_W'(1));
    end else if (wkt_run_q && lp_osc_tick) begin
      wkt_q <= wkt_q - WKT_W'(1);
      if (wkt_q == WKT_W'(1)) begin
        wkt_run_q <= 1'b0;
        wkt_exp_q <= 1'b1;
      end
    end else if (state_q == WRC_ST_RUN && state_d != WRC_ST_RUN) begin
      wkt_exp_q <= wkt_exp_q;
    end
  end

  // Registered outputs.
  // They follow the next state so that they switch on the same edge as the state.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      core_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
      deep_clocks_off <= 1'b0;
      dpd_power_off <= 1'b0;
      fro_enable <= 1'b1;
      flash_init <= 1'b0;
      chip_reset <= 1'b1;
      core_reset <= 1'b1;
      fetch_addr <= WRC_RESET_VECTOR;
    end else begin
      core_clk_en <= (state_d == WRC_ST_RUN);
      periph_clk_en <= (state_d == WRC_ST_RUN) || (state_d == WRC_ST_SLEEP);
      deep_clocks_off <= (state_d == WRC_ST_DEEP);
      dpd_power_off <= (state_d == WRC_ST_DPD);
      fro_enable <= (state_d != WRC_ST_DPD);
      flash_init <= (state_d == WRC_ST_INIT);
      chip_reset <= (state_d == WRC_ST_RESET);
      core_reset <= (state_d == WRC_ST_RESET) || (state_d == WRC_ST_INIT);
      if (state_d == WRC_ST_RESET) begin
        fetch_addr <= WRC_RESET_VECTOR;
      end
    end
  end

  assign wkt_count = wkt_q;
  assign wkt_expired = wkt_exp_q;
  assign reset_cause = cause_q;

endmodule

/* File: wrc_checker.sv */
// Concurrent checks on the wake-up and reset controller ports.
`timescale 1ns/1ns
module wrc_checker #(
  parameter int WKT_W = 32,
  parameter int INIT_CYCLES = 20
) (
  // Clock, reset and controller inputs
  input wire logic core_clk,
  input wire logic reset,
  input wire logic irq_any_enabled,
  input wire logic por_detect,
  input wire logic wkt_count_wr,
  input wire logic [WKT_W-1:0] wkt_count_val,
  input wire logic lp_osc_tick,
  // Controller outputs
  input wire logic core_clk_en,
  input wire logic periph_clk_en,
  input wire logic deep_clocks_off,
  input wire logic dpd_power_off,
  input wire logic fro_enable,
  input wire logic flash_init,
  input wire logic chip_reset,
  input wire logic core_reset,
  input wire logic [31:0] fetch_addr,
  input wire logic wake_req,
  input wire logic [WKT_W-1:0] wkt_count,
  input wire logic wkt_expired
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic asleep;
  assign asleep = !core_clk_en && !core_reset && !deep_clocks_off && !dpd_power_off;
  // The last tick of a running count; an expiry there survives a new count write.
  logic wkt_end;
  assign wkt_end = lp_osc_tick && (wkt_count == WKT_W'(1));
  a_fetch_addr_zero: assert property (fetch_addr == 32'h0)
    else $error("fetch address is not zero");
  a_por_chip_reset: assert property (por_detect && !dpd_power_off |=> chip_reset)
    else $error("power-on detect did not raise chip reset");
  a_reset_fro_on: assert property (chip_reset |-> fro_enable)
    else $error("chip reset without oscillator start");
  a_init_holds_core: assert property (flash_init |-> core_reset)
    else $error("core released during flash init");
  a_run_on_fro: assert property (core_clk_en |-> fro_enable)
    else $error("core clocked without internal oscillator");
  a_dpd_all_off: assert property (dpd_power_off |-> !core_clk_en && !periph_clk_en)
    else $error("clocks running in deep power-down");
  a_sleep_periph_on: assert property (asleep |-> periph_clk_en)
    else $error("peripheral clock stopped in sleep");
  a_sleep_irq_wake: assert property (asleep && irq_any_enabled |-> wake_req ##1 core_clk_en)
    else $error("enabled interrupt did not wake sleep");
  a_wkt_count_load: assert property (wkt_count_wr && wkt_count_val != '0 |=>
    wkt_count == $past(wkt_count_val) && wkt_expired == $past(wkt_end))
    else $error("timer count write not taken");
  c_sleep_wake: cover property (asleep && wake_req);
  c_deep_wake: cover property (deep_clocks_off && wake_req);
  c_dpd_wake: cover property (dpd_power_off && wake_req);
endmodule
bind wrc_wakeup_reset_ctrl wrc_checker #(.WKT_W(WKT_W), .INIT_CYCLES(INIT_CYCLES)) u_chk (
  .core_clk, .reset, .irq_any_enabled, .por_detect, .wkt_count_wr, .wkt_count_val, .lp_osc_tick,
  .core_clk_en, .periph_clk_en, .deep_clocks_off, .dpd_power_off, .fro_enable, .flash_init,
  .chip_reset, .core_reset, .fetch_addr, .wake_req, .wkt_count, .wkt_expired);

/* File: wrc_periph_model.sv */
// Behavioural model of the low-power oscillator and the wake-capable peripherals.
`timescale 1ns/1ns
module wrc_periph_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic fire,
  input wire logic clear,
  input wire logic [2:0] src,
  input wire logic [3:0] lat,
  output logic [5:0] ev,
  output logic lp_osc_tick
);
  logic [3:0] cnt_q;
  logic [2:0] src_q;
  logic arm_q;
  logic [1:0] div_q;
  // The low-power clock is much slower than the core, so the timer sees one tick in four.
  always_ff @(posedge core_clk) begin
    div_q <= reset ? 2'h0 : div_q + 2'h1;
    lp_osc_tick <= !reset && (div_q == 2'h3);
  end
  // Events come promptly or late and stay raised until the processor has served them.
  always_ff @(posedge core_clk) begin
    if (reset || clear) begin
      ev <= 6'h0;
      arm_q <= 1'b0;
      cnt_q <= 4'h0;
      src_q <= 3'h0;
    end else if (fire) begin
      arm_q <= 1'b1;
      cnt_q <= lat;
      src_q <= src;
    end else if (arm_q && cnt_q == 4'h0) begin
      arm_q <= 1'b0;
      ev[src_q] <= 1'b1;
    end else if (arm_q) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule

/* File: wrc_testbench.sv */
// Self-checking testbench for the wake-up and reset controller.
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module testbench;
  import wrc_pkg::*;
  logic core_clk = 1'b0;
  logic reset, mode_req, wkt_count_wr, wk, fire, clr, tick, ok;
  wrc_mode_t mode_sel;
  logic [27:0] en;
  logic [3:0] rs, lat, reset_cause;
  logic [2:0] src;
  logic [5:0] ev;
  logic [31:0] wkt_count_val, fetch_addr, wkt_count, v;
  logic core_clk_en, periph_clk_en, deep_clocks_off, dpd_power_off, fro_enable, flash_init;
  logic chip_reset, core_reset, wake_req, wkt_expired;
  int num_errors = 0;
  int total_checks = 0;
  // The core only ever runs on this one clock; no other source is selected or awaited.
  always #25 core_clk = ~core_clk;
  wrc_periph_model u_model (.core_clk, .reset, .fire, .clear(clr), .src, .lat, .ev,
    .lp_osc_tick(tick));
  wrc_wakeup_reset_ctrl #(.INIT_CYCLES(2)) u_dut (.core_clk, .reset, .mode_req, .mode_sel,
    .irq_any_enabled(ev[0]), .pin_irq(ev[1]), .bod_irq(ev[2]), .wdog_irq(ev[3]),
    .serial_irq(ev[4]), .touch_irq(ev[5]), .pin_function_reset_en(en[0]),
    .pin_wake_start_enable(en[1]), .bod_wake_start_en(en[2]), .wdog_wake_start_en(en[3]),
    .serial_wake_start_en(en[4]), .touch_wake_start_en(en[5]), .wkt_wake_start_en(en[6]),
    .dpd_wakeup_pin_en(en[7]), .dpd_reset_pin_en(en[8]), .pin_irq_nested_irq_controller_en(en[9]),
    .bod_irq_nested_irq_controller_en(en[10]), .wdog_irq_nested_irq_controller_en(en[11]), .serial_irq_nested_irq_controller_en(en[12]),
    .touch_irq_nested_irq_controller_en(en[13]), .wkt_irq_nested_irq_controller_en(en[14]), .brownout_control_irq_en(en[15]),
    .brownout_control_rst_en(en[16]), .sleep_power_config_bod_on(en[17]),
    .wdog_running(en[18]), .watchdog_mode_reg_irq_en(en[19]),
    .watchdog_mode_reg_rst_en(en[20]), .sleep_power_config_watchdog_oscillator_on(en[21]),
    .wkt_clk_lowpower_sel(en[22]), .serial_slave_mode(en[23]), .serial_ext_clk(en[24]),
    .touch_clk_from_watchdog_oscillator(en[25]), .dpd_lp_osc_en(en[26]), .dpd_lp_osc_keep(en[27]),
    .reset_pin_n(~rs[0]), .wdog_reset_req(rs[1]), .por_detect(rs[2]),
    .brownout_detect(rs[3]), .wakeup_pin_n(~wk), .wkt_count_wr, .wkt_count_val,
    .lp_osc_tick(tick), .core_clk_en, .periph_clk_en, .deep_clocks_off, .dpd_power_off,
    .fro_enable, .flash_init, .chip_reset, .core_reset, .fetch_addr, .wake_req,
    .wkt_count, .wkt_expired, .reset_cause);
  function automatic logic wake_exp(input logic [27:0] e, input int s);
    return e[s] & e[s + 8];
  endfunction
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // A wait that must succeed and runs out of time ends the run at once.
  task automatic wait_run(input int n, input logic must, output logic got);
    got = 1'b0;
    for (int i = 0; i < n && !got; i++) begin
      @(posedge core_clk);
      #1 got = (core_clk_en === 1'b1) && (core_reset === 1'b0);
    end
    if (must && !got) begin
      num_errors++;
      give_verdict();
    end
  endtask
  task automatic enter(input wrc_mode_t m);
    @(posedge core_clk);
    mode_req <= 1'b1;
    mode_sel <= m;
    @(posedge core_clk);
    mode_req <= 1'b0;
    cyc(2);
  endtask
  task automatic raise(input int s);
    @(posedge core_clk);
    fire <= 1'b1;
    src <= s[2:0];
    lat <= 4'($urandom_range(9));
    @(posedge core_clk);
    fire <= 1'b0;
  endtask
  task automatic lower();
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
  endtask
  initial begin
    {reset, mode_req, wkt_count_wr, wk, fire, clr} = 6'h20;
    {rs, lat, src, wkt_count_val} = '0;
    mode_sel = WRC_MODE_RUN;
    en = '1;
    void'($urandom(32'hcdd8e15f));
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    wait_run(60, 1'b1, ok);
    `CHK(fetch_addr, 32'h0)
    `CHK(fro_enable, 1'b1)
    $display("test power-up done");
    for (int k = 0; k < 4; k++) begin
      enter(WRC_MODE_SLEEP);
      `CHK({core_clk_en, periph_clk_en}, 2'h1)
      raise(0);
      wait_run(30, 1'b1, ok);
      lower();
    end
    $display("test sleep done");
    for (int s = 1; s < 6; s++) begin
      @(posedge core_clk);
      en[(s % 2) ? s : s + 8] <= 1'b0;
      enter((s % 2) ? WRC_MODE_DEEP_SLEEP : WRC_MODE_POWER_DOWN);
      `CHK({deep_clocks_off, periph_clk_en}, 2'h2)
      raise(s);
      wait_run(20, 1'b0, ok);
      `CHK(ok, wake_exp(en, s))
      @(posedge core_clk);
      en <= '1;
      wait_run(40, 1'b1, ok);
      lower();
    end
    $display("test deep wake done");
    for (int p = 0; p < 2; p++) begin
      @(posedge core_clk);
      en[8 - p] <= 1'b0;
      en[26] <= 1'b0;
      enter(WRC_MODE_DEEP_PD);
      `CHK(dpd_power_off, 1'b1)
      @(posedge core_clk);
      if (p == 0) rs[0] <= 1'b1;
      else wk <= 1'b1;
      wait_run(20, 1'b0, ok);
      `CHK(ok, 1'b0)
      @(posedge core_clk);
      en <= '1;
      repeat (4) @(posedge core_clk);
      {rs[0], wk} <= 2'h0;
      wait_run(60, 1'b1, ok);
    end
    $display("test deep power-down done");
    v = 32'($urandom_range(12, 4));
    @(posedge core_clk);
    wkt_count_wr <= 1'b1;
    wkt_count_val <= v;
    @(posedge core_clk);
    wkt_count_wr <= 1'b0;
    enter(WRC_MODE_POWER_DOWN);
    wait_run(200, 1'b1, ok);
    `CHK(wkt_expired, 1'b1)
    $display("test self-wake timer done");
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      rs <= 4'h1 << i;
      cyc(3);
      `CHK({chip_reset, fro_enable}, 2'h3)
      @(posedge core_clk);
      rs <= 4'h0;
      cyc(1);
      `CHK({flash_init, core_reset, chip_reset}, 3'h6)
      wait_run(60, 1'b1, ok);
      `CHK(reset_cause, 4'h1 << i)
    end
    $display("test reset sources done");
    give_verdict();
  end
endmodule
